// [logic/nvsc_host.sv]
// host controller driving the nv shadow sram pins
`timescale 1ns/1ps
`default_nettype none
`include "nvsc_map.svh"
module nvsc_host #(
  parameter int ACCESS_CYC = `NVSC_ACCESS_CYC,
  parameter int SETUP_CYC = `NVSC_SETUP_CYC,
  parameter int GRACE_CYC = `NVSC_GRACE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire nvsc_pkg::nvsc_op_e req_op,
  input wire nvsc_pkg::nvsc_addr_t req_addr,
  input wire nvsc_pkg::nvsc_data_t req_wdata,
  output logic rsp_valid,
  output nvsc_pkg::nvsc_data_t rsp_rdata,
  output logic store_seen,
  output logic chip_select_n,
  output logic write_enable_n,
  output logic output_enable_n,
  output nvsc_pkg::nvsc_addr_t byte_address,
  input wire nvsc_pkg::nvsc_data_t data_lines_in,
  output nvsc_pkg::nvsc_data_t data_lines_out,
  output logic data_lines_oe,
  input wire logic store_busy_n_in,
  output logic store_busy_n_out,
  output logic store_busy_n_oe
);
  import nvsc_pkg::*;

  if (ACCESS_CYC < 1 || SETUP_CYC < 1 || GRACE_CYC < 1 ||
      ACCESS_CYC > 65535 || SETUP_CYC > 65535 || GRACE_CYC > 65535) begin : g_bad_cycles
    $error("nvsc_host: cycle counts out of range");
  end

  typedef enum logic [2:0] {
    NVSC_IDLE = 3'h0,
    NVSC_ACCESS = 3'h1,
    NVSC_RECOVER = 3'h2,
    NVSC_HSB_PULL = 3'h3,
    NVSC_BUSY_WAIT = 3'h4
  } nvsc_state_e;

  nvsc_busy_if bif ();
  nvsc_busy_watch u_watch (
    .clk_sys(clk_sys),
    .rst(rst),
    .store_busy_n_in(store_busy_n_in),
    .bw(bif.watcher)
  );

  function automatic nvsc_addr_t seq_addr(input logic [2:0] idx);
    unique case (idx)
      3'h0: seq_addr = `NVSC_SEQ0;
      3'h1: seq_addr = `NVSC_SEQ1;
      3'h2: seq_addr = `NVSC_SEQ2;
      3'h3: seq_addr = `NVSC_SEQ3;
      3'h4: seq_addr = `NVSC_SEQ4;
      default: seq_addr = `NVSC_SEQ5;
    endcase
  endfunction

  nvsc_state_e state;
  nvsc_state_e next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic is_write;
  logic next_is_write;
  logic is_sw;
  logic next_is_sw;
  logic [2:0] seq_idx;
  logic [2:0] next_seq_idx;
  logic ce_n;
  logic next_ce_n;
  logic we_n;
  logic next_we_n;
  logic oe_n;
  logic next_oe_n;
  nvsc_addr_t addr;
  nvsc_addr_t next_addr;
  nvsc_data_t wdata;
  nvsc_data_t next_wdata;
  logic drive;
  logic next_drive;
  nvsc_data_t rdata;
  nvsc_data_t next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic seen;
  logic next_seen;

  // accept only when idle and device not busy
  assign req_ready = (state == NVSC_IDLE) && !bif.busy_low;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_is_write = is_write;
    next_is_sw = is_sw;
    next_seq_idx = seq_idx;
    next_ce_n = ce_n;
    next_we_n = we_n;
    next_oe_n = oe_n;
    next_addr = addr;
    next_wdata = wdata;
    next_drive = drive;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_seen = bif.busy_fall ? 1'b1 : seen;
    unique case (state)
      NVSC_IDLE: begin
        if (bif.busy_low) begin
          next_state = NVSC_BUSY_WAIT;
        end else if (req_valid) begin
          next_cnt = 16'(ACCESS_CYC);
          next_ce_n = 1'b0;
          next_is_sw = 1'b0;
          next_is_write = 1'b0;
          next_state = NVSC_ACCESS;
          unique case (req_op)
            NVSC_OP_WRITE: begin
              // address set with enables, output enable kept high
              next_addr = req_addr;
              next_wdata = req_wdata;
              next_is_write = 1'b1;
              next_we_n = 1'b0;
              next_drive = 1'b1;
            end
            NVSC_OP_SW_STORE: begin
              next_addr = seq_addr(3'h0);
              next_seq_idx = 3'h0;
              next_is_sw = 1'b1;
            end
            NVSC_OP_HW_STORE: begin
              next_ce_n = 1'b1;
              next_cnt = 16'(GRACE_CYC);
              next_state = NVSC_HSB_PULL;
            end
            default: begin
              next_addr = req_addr;
              next_oe_n = 1'b0;
            end
          endcase
        end
      end
      NVSC_ACCESS: begin
        if (cnt > 16'h0001) begin
          next_cnt = cnt - 16'h0001;
        end else begin
          // end of access: read data captured from the data lines; write data latched by device on write-enable rise
          if (!is_write) begin
            next_rdata = data_lines_in;
            next_rvalid = !is_sw;
          end
          next_ce_n = 1'b1;
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
          next_cnt = 16'(SETUP_CYC);
          next_state = NVSC_RECOVER;
        end
      end
      NVSC_RECOVER: begin
        next_drive = 1'b0;
        if (cnt > 16'h0001) begin
          next_cnt = cnt - 16'h0001;
        end else if (is_sw && seq_idx != 3'(`NVSC_SEQ_LEN - 1)) begin
          // back-to-back reads with nothing between them
          next_seq_idx = seq_idx + 3'h1;
          next_addr = seq_addr(seq_idx + 3'h1);
          next_ce_n = 1'b0;
          next_cnt = 16'(ACCESS_CYC);
          next_state = NVSC_ACCESS;
        end else if (is_sw) begin
          next_cnt = 16'(GRACE_CYC);
          next_state = NVSC_BUSY_WAIT;
        end else begin
          next_state = NVSC_IDLE;
        end
      end
      NVSC_HSB_PULL: begin
        if (cnt > 16'h0001) begin
          next_cnt = cnt - 16'h0001;
        end else begin
          next_state = NVSC_BUSY_WAIT;
        end
      end
      NVSC_BUSY_WAIT: begin
        // wait for store end; grace first in case line falls late
        if (cnt > 16'h0000) begin
          next_cnt = cnt - 16'h0001;
        end else if (!bif.busy_low) begin
          next_state = NVSC_IDLE;
        end
      end
      default: next_state = NVSC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= NVSC_IDLE;
      cnt <= 16'h0000;
      is_write <= 1'b0;
      is_sw <= 1'b0;
      seq_idx <= 3'h0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      addr <= 17'h00000;
      wdata <= 8'h00;
      drive <= 1'b0;
      rdata <= 8'h00;
      rvalid <= 1'b0;
      seen <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      is_write <= next_is_write;
      is_sw <= next_is_sw;
      seq_idx <= next_seq_idx;
      ce_n <= next_ce_n;
      we_n <= next_we_n;
      oe_n <= next_oe_n;
      addr <= next_addr;
      wdata <= next_wdata;
      drive <= next_drive;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      seen <= next_seen;
    end
  end

  assign chip_select_n = ce_n;
  assign write_enable_n = we_n;
  assign output_enable_n = oe_n;
  assign byte_address = addr;
  assign data_lines_out = wdata;
  assign data_lines_oe = drive;
  assign rsp_valid = rvalid;
  assign rsp_rdata = rdata;
  assign store_seen = seen;
  assign store_busy_n_out = 1'b0;
  assign store_busy_n_oe = (state == NVSC_HSB_PULL);

  property p_no_contention;
    @(posedge clk_sys) disable iff (rst) !(data_lines_oe && !output_enable_n);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("bus contention");

  property p_addr_stable_write;
    @(posedge clk_sys) disable iff (rst)
      (!write_enable_n && $past(!write_enable_n)) |-> $stable(byte_address);
  endproperty
  a_addr_stable_write: assert property (p_addr_stable_write) else $error("address moved");

  property p_read_controls;
    @(posedge clk_sys) disable iff (rst)
      !output_enable_n |-> (!chip_select_n && write_enable_n);
  endproperty
  a_read_controls: assert property (p_read_controls) else $error("bad read controls");

  property p_write_controls;
    @(posedge clk_sys) disable iff (rst)
      !write_enable_n |-> (!chip_select_n && data_lines_oe);
  endproperty
  a_write_controls: assert property (p_write_controls) else $error("bad write controls");

  property p_no_access_busy;
    @(posedge clk_sys) disable iff (rst)
      $fell(chip_select_n) |-> $past(state) == NVSC_IDLE || $past(is_sw);
  endproperty
  a_no_access_busy: assert property (p_no_access_busy) else $error("access while busy");

  property p_hsb_pull_only;
    @(posedge clk_sys) disable iff (rst)
      store_busy_n_oe |-> chip_select_n && write_enable_n;
  endproperty
  a_hsb_pull_only: assert property (p_hsb_pull_only) else $error("access during pull");

  property p_seq_first;
    @(posedge clk_sys) disable iff (rst)
      (state == NVSC_IDLE && req_valid && req_ready && req_op == NVSC_OP_SW_STORE)
        |=> byte_address == `NVSC_SEQ0 && !chip_select_n;
  endproperty
  a_seq_first: assert property (p_seq_first) else $error("sequence start wrong");

  property p_seq_no_write;
    @(posedge clk_sys) disable iff (rst)
      is_sw && state != NVSC_IDLE |-> write_enable_n;
  endproperty
  a_seq_no_write: assert property (p_seq_no_write) else $error("write in sequence");

  property p_read_rsp;
    @(posedge clk_sys) disable iff (rst)
      rsp_valid |-> $past(!output_enable_n) && chip_select_n;
  endproperty
  a_read_rsp: assert property (p_read_rsp) else $error("response without read");
endmodule
`default_nettype wire

// [pkg/nvsc_map.svh]
// constants for the nv shadow sram host controller
// Operation
// - host holds address stable across the whole write
// - host keeps output enable high during writes
// - host pulling busy line low requests a store
// - host watches busy line to see automatic stores
// - six reads from 0x4E38 to 0x8FC0 start a software store
`ifndef NVSC_MAP_SVH
`define NVSC_MAP_SVH
`define NVSC_ADDR_W 17
`define NVSC_DATA_W 8
`define NVSC_CLK_MHZ 125
`define NVSC_T_ACCESS_NS 45
`define NVSC_ACCESS_CYC ((`NVSC_T_ACCESS_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_T_SETUP_NS 20
`define NVSC_SETUP_CYC ((`NVSC_T_SETUP_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_T_GRACE_NS 25000
`define NVSC_GRACE_CYC ((`NVSC_T_GRACE_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_SEQ_LEN 6
`define NVSC_SEQ0 17'h04E38
`define NVSC_SEQ1 17'h0B1C7
`define NVSC_SEQ2 17'h083E0
`define NVSC_SEQ3 17'h07C1F
`define NVSC_SEQ4 17'h0703F
`define NVSC_SEQ5 17'h08FC0
`endif

// [pkg/nvsc_pkg.sv]
// types for the nv shadow sram host controller
package nvsc_pkg;
  typedef enum logic [2:0] {
    NVSC_OP_READ = 3'h0,
    NVSC_OP_WRITE = 3'h1,
    NVSC_OP_SW_STORE = 3'h2,
    NVSC_OP_HW_STORE = 3'h3
  } nvsc_op_e;
  typedef logic [16:0] nvsc_addr_t;
  typedef logic [7:0] nvsc_data_t;
endpackage

// [pkg/nvsc_busy_if.sv]
// busy line status carried between controller and its busy watcher
`timescale 1ns/1ps
`default_nettype none
interface nvsc_busy_if;
  logic busy_low;
  logic busy_fall;
  logic busy_rise;
  modport watcher (output busy_low, output busy_fall, output busy_rise);
  modport user (input busy_low, input busy_fall, input busy_rise);
endinterface
`default_nettype wire

// [logic/nvsc_busy_watch.sv]
// synchroniser and edge detector for the store busy pin
`timescale 1ns/1ps
`default_nettype none
module nvsc_busy_watch (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic store_busy_n_in,
  nvsc_busy_if.watcher bw
);
  logic sync1;
  logic sync2;
  logic prev;
  logic next_sync1;
  logic next_sync2;
  logic next_prev;

  always_comb begin
    next_sync1 = store_busy_n_in;
    next_sync2 = sync1;
    next_prev = sync2;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      prev <= 1'b1;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev <= next_prev;
    end
  end

  // host sees automatic stores through the busy line
  assign bw.busy_low = ~sync2;
  assign bw.busy_fall = prev & ~sync2;
  assign bw.busy_rise = ~prev & sync2;
endmodule
`default_nettype wire

// [bench/nvsc_dev_model.sv]
// behavioural model of the nv shadow sram device
`timescale 1ns/1ps
`default_nettype none
`include "nvsc_map.svh"
module nvsc_dev_model #(
  parameter int STORE_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic chip_select_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire nvsc_pkg::nvsc_addr_t byte_address,
  input wire nvsc_pkg::nvsc_data_t data_host,
  input wire logic host_busy_oe,
  input wire logic power_fail,
  output logic busy_line,
  output nvsc_pkg::nvsc_data_t data_dev,
  output int store_count
);
  import nvsc_pkg::*;
  nvsc_data_t mem [0:131071];
  nvsc_data_t nv [0:131071];
  nvsc_data_t last_q = 8'h00;
  nvsc_addr_t seq [6] = '{`NVSC_SEQ0, `NVSC_SEQ1, `NVSC_SEQ2, `NVSC_SEQ3, `NVSC_SEQ4, `NVSC_SEQ5};
  logic written = 1'b0;
  logic cs_q = 1'b1;
  logic we_q = 1'b1;
  logic req_q = 1'b0;
  int busy_cnt = 0;
  int pos = 0;
  int stores = 0;
  logic reading;
  assign store_count = stores;
  // pull-up, pulled low while storing
  assign busy_line = !(host_busy_oe || busy_cnt > 0);
  assign reading = !chip_select_n && !output_enable_n && write_enable_n && busy_line;
  // follows address, released line shows inverse
  assign data_dev = reading ? mem[byte_address] : ~last_q;
  always @(posedge clk_sys) begin
    cs_q <= chip_select_n;
    we_q <= write_enable_n;
    req_q <= host_busy_oe || power_fail;
    if (reading) last_q <= mem[byte_address];
    if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
      if (busy_cnt == 1) written <= 1'b0;
    end else if ((host_busy_oe || power_fail) && !req_q && written) begin
      busy_cnt <= STORE_CYC;
      stores <= stores + 1;
      nv <= mem;
    end else if (!cs_q && !we_q && (chip_select_n || write_enable_n)) begin
      mem[byte_address] <= data_host;
      written <= 1'b1;
      pos <= 0;
    end else if (!cs_q && we_q && chip_select_n) begin
      if (byte_address != seq[pos]) pos <= (byte_address == seq[0]) ? 1 : 0;
      else if (pos < 5) pos <= pos + 1;
      else begin
        pos <= 0;
        busy_cnt <= STORE_CYC;
        stores <= stores + 1;
        nv <= mem;
      end
    end
  end
endmodule
`default_nettype wire

// [bench/nvsc_host_tb.sv]
// self-checking bench for the nv shadow sram host controller
`timescale 1ns/1ps
`default_nettype none
`include "nvsc_map.svh"
module nvsc_host_tb;
  import nvsc_pkg::*;
  localparam int ACC = 6;
  logic clk_sys;
  logic rst;
  logic req_valid;
  logic req_ready;
  nvsc_op_e req_op;
  nvsc_addr_t req_addr;
  nvsc_data_t req_wdata;
  logic rsp_valid;
  nvsc_data_t rsp_rdata;
  logic store_seen;
  logic cs_n;
  logic we_n;
  logic oe_n;
  nvsc_addr_t addr;
  nvsc_data_t dq_out;
  nvsc_data_t dq_dev;
  nvsc_data_t dq_bus;
  logic dq_oe;
  logic busy_line;
  logic busy_oe;
  logic busy_out;
  logic power_fail;
  int store_count;
  int bad_count = 0;
  int n_compared = 0;
  int n;
  nvsc_data_t r;
  nvsc_addr_t seq [6] = '{`NVSC_SEQ0, `NVSC_SEQ1, `NVSC_SEQ2, `NVSC_SEQ3, `NVSC_SEQ4, `NVSC_SEQ5};
  assign dq_bus = dq_oe ? dq_out : dq_dev;
  nvsc_host #(.ACCESS_CYC(ACC), .SETUP_CYC(3), .GRACE_CYC(4)) uut (.clk_sys(clk_sys), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .store_seen(store_seen),
    .chip_select_n(cs_n), .write_enable_n(we_n), .output_enable_n(oe_n), .byte_address(addr),
    .data_lines_in(dq_bus), .data_lines_out(dq_out), .data_lines_oe(dq_oe),
    .store_busy_n_in(busy_line), .store_busy_n_out(busy_out), .store_busy_n_oe(busy_oe));
  nvsc_dev_model #(.STORE_CYC(20)) dev (.clk_sys(clk_sys), .chip_select_n(cs_n),
    .write_enable_n(we_n), .output_enable_n(oe_n), .byte_address(addr), .data_host(dq_bus),
    .host_busy_oe(busy_oe && !busy_out), .power_fail(power_fail), .busy_line(busy_line),
    .data_dev(dq_dev), .store_count(store_count));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic do_req(input nvsc_op_e op, input nvsc_addr_t a, input nvsc_data_t d);
    while (req_ready !== 1'b1) @(negedge clk_sys);
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
  endtask
  task automatic rd(input nvsc_addr_t a, output nvsc_data_t d);
    int k;
    do_req(NVSC_OP_READ, a, 8'h00);
    k = 0;
    while (rsp_valid !== 1'b1 && k < 40) begin
      @(negedge clk_sys);
      k++;
    end
    check("read latency", k, ACC);
    d = rsp_rdata;
  endtask
  task automatic wait_idle();
    n = 0;
    repeat (2) @(negedge clk_sys);
    while (req_ready !== 1'b1 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    check("req_ready", req_ready, 1'b1);
  endtask
  task automatic pulse_power();
    power_fail = 1'b1;
    @(negedge clk_sys);
    power_fail = 1'b0;
    wait_idle();
  endtask
  task automatic t_hw_skip();
    do_req(NVSC_OP_HW_STORE, 17'h00000, 8'h00);
    wait_idle();
    check("store count", store_count, 0);
    check("store_seen", store_seen, 1'b1);
    $display("test hw_skip done");
  endtask
  task automatic t_rw();
    nvsc_addr_t a [4] = '{17'h00000, 17'h1FFFF, 17'h0AAAA, 17'h15555};
    nvsc_data_t d [4] = '{8'h5A, 8'hA5, 8'h3C, 8'hC3};
    for (int i = 0; i < 4; i++) do_req(NVSC_OP_WRITE, a[i], d[i]);
    for (int i = 0; i < 4; i++) begin
      rd(a[i], r);
      check("read data", r, d[i]);
    end
    $display("test rw done");
  endtask
  task automatic t_hw_store();
    do_req(NVSC_OP_WRITE, 17'h00100, 8'h11);
    do_req(NVSC_OP_HW_STORE, 17'h00000, 8'h00);
    wait_idle();
    check("store count", store_count, 1);
    check("busy hold", n >= 12, 1'b1);
    $display("test hw_store done");
  endtask
  task automatic t_sw_store();
    do_req(NVSC_OP_SW_STORE, 17'h00000, 8'h00);
    wait_idle();
    check("store count", store_count, 2);
    rd(17'h00100, r);
    check("read after store", r, 8'h11);
    $display("test sw_store done");
  endtask
  task automatic t_abort();
    for (int i = 0; i < 3; i++) rd(seq[i], r);
    do_req(NVSC_OP_WRITE, 17'h0AAAA, 8'h77);
    for (int i = 3; i < 6; i++) rd(seq[i], r);
    wait_idle();
    check("store count", store_count, 2);
    rd(17'h0AAAA, r);
    check("read data", r, 8'h77);
    $display("test abort done");
  endtask
  task automatic t_power();
    pulse_power();
    check("store count", store_count, 3);
    pulse_power();
    check("store count", store_count, 3);
    $display("test power done");
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = NVSC_OP_READ;
    req_addr = 17'h00000;
    req_wdata = 8'h00;
    power_fail = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    t_hw_skip();
    t_rw();
    t_hw_store();
    t_sw_store();
    t_abort();
    t_power();
    report_and_stop();
  end
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
